// ===== pkg/ldi_pkg.sv
package ldi_pkg;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned ADDR_BITS = 7;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h15;
  localparam int unsigned LED_COUNT = 16;
  localparam logic LED_LEVEL_RESET = 1'b1;
  localparam logic LED_OPEN_DRAIN_RESET = 1'b0;
  localparam logic SDA_RELEASED = 1'b1;
  localparam logic SDA_DRIVEN = 1'b0;
  localparam logic RW_READ = 1'b1;
  typedef enum logic [2:0] {
    LDI_IDLE = 3'b000,
    LDI_ADDR = 3'b001,
    LDI_ADDR_ACK = 3'b010,
    LDI_WRITE = 3'b011,
    LDI_WRITE_ACK = 3'b100,
    LDI_READ = 3'b101,
    LDI_READ_ACK = 3'b110,
    LDI_IGNORE = 3'b111
  } ldi_state_t;
endpackage

// ===== src/ldi_sync.sv
`timescale 1ns/1ps
module ldi_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // resets high: an idle two-wire bus rests high
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_r <= '1;
      stage2_r <= '1;
    end
    else
    begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;
endmodule

// ===== src/ldi_link.sv
`timescale 1ns/1ps
// Behaviour
// - idle bus: both lines high, nobody holds them low
// - one bit per clock pulse, data stable while clock high
// - data falling while clock high is start; begin a fresh address byte
// - data rising while clock high is stop; end transfer, go idle
// - no limit on byte count between start and stop
// - eight bits, msb first, then a ninth acknowledge clock
// - transmitter releases data during acknowledge; master supplies ninth pulse
// - addressed receiving device acknowledges every byte, address included
// - acknowledger pulls data low before clock rises, holds through high phase
// - after a not-acknowledge the device releases data until stop
// - while low-power bit is set, led outputs do not change
// - after power-up outputs are push-pull and driven high
module ldi_link #(
  parameter logic [6:0] DEV_ADDR = ldi_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned LEDS = ldi_pkg::LED_COUNT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic [7:0] wr_data,
  output logic wr_valid,
  output logic wr_first,
  input wire logic [7:0] rd_data,
  output logic rd_taken,
  output logic busy,
  input wire logic low_power,
  input wire logic [LEDS-1:0] led_target,
  input wire logic open_drain_sel,
  output logic [LEDS-1:0] led_level,
  output logic led_open_drain
);
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  ldi_sync #(.WIDTH(2)) u_sync (.clk_sys(clk_sys), .reset_n(reset_n), .async_in({scl_i, sda_i}),
    .sync_out(pins_s));
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  // only sampled, both already two flops deep
  assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s;
  ldi_pkg::ldi_state_t state_r;
  ldi_pkg::ldi_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic acked_r;
  logic acked_nxt;
  logic first_r;
  logic first_nxt;
  logic [7:0] wr_data_r;
  logic [7:0] wr_data_nxt;
  logic wr_valid_r;
  logic wr_valid_nxt;
  logic wr_first_r;
  logic wr_first_nxt;
  logic rd_taken_r;
  logic rd_taken_nxt;
  logic busy_r;
  logic busy_nxt;
  // drive low only for a zero bit; a one is a released line
  function automatic logic bit_oe_n(input logic b);
    bit_oe_n = b ? ldi_pkg::SDA_RELEASED : ldi_pkg::SDA_DRIVEN;
  endfunction
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    oe_n_nxt = oe_n_r;
    acked_nxt = acked_r;
    first_nxt = first_r;
    wr_data_nxt = wr_data_r;
    wr_valid_nxt = 1'b0;
    wr_first_nxt = wr_first_r;
    rd_taken_nxt = 1'b0;
    busy_nxt = (state_r != ldi_pkg::LDI_IDLE);
    if (stop_seen)
    begin
      state_nxt = ldi_pkg::LDI_IDLE;
      oe_n_nxt = ldi_pkg::SDA_RELEASED;
      busy_nxt = 1'b0;
    end
    else if (start_seen)
    begin
      // repeated start is honoured in any state
      state_nxt = ldi_pkg::LDI_ADDR;
      cnt_nxt = ldi_pkg::CNT_ZERO;
      oe_n_nxt = ldi_pkg::SDA_RELEASED;
      busy_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        ldi_pkg::LDI_IDLE, ldi_pkg::LDI_IGNORE:
        begin
          oe_n_nxt = ldi_pkg::SDA_RELEASED;
        end
        ldi_pkg::LDI_ADDR, ldi_pkg::LDI_WRITE:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + ldi_pkg::CNT_ONE;
          end
          else if (scl_fall && cnt_r == ldi_pkg::BIT_LAST)
          begin
            cnt_nxt = ldi_pkg::CNT_ZERO;
            if (state_r == ldi_pkg::LDI_ADDR)
            begin
              if (shift_r[7:1] == DEV_ADDR)
              begin
                // ack goes low on the fall, well before the ninth rise
                oe_n_nxt = ldi_pkg::SDA_DRIVEN;
                acked_nxt = (shift_r[0] == ldi_pkg::RW_READ);
                first_nxt = 1'b1;
                state_nxt = ldi_pkg::LDI_ADDR_ACK;
              end
              else
              begin
                state_nxt = ldi_pkg::LDI_IGNORE;
              end
            end
            else
            begin
              wr_data_nxt = shift_r;
              wr_valid_nxt = 1'b1;
              wr_first_nxt = first_r;
              first_nxt = 1'b0;
              oe_n_nxt = ldi_pkg::SDA_DRIVEN;
              state_nxt = ldi_pkg::LDI_WRITE_ACK;
            end
          end
        end
        ldi_pkg::LDI_ADDR_ACK, ldi_pkg::LDI_WRITE_ACK:
        begin
          if (scl_fall)
          begin
            // acked_r holds the read direction during the address ack
            if (state_r == ldi_pkg::LDI_ADDR_ACK && acked_r)
            begin
              tx_nxt = {rd_data[6:0], 1'b0};
              oe_n_nxt = bit_oe_n(rd_data[7]);
              rd_taken_nxt = 1'b1;
              cnt_nxt = ldi_pkg::CNT_ZERO;
              state_nxt = ldi_pkg::LDI_READ;
            end
            else
            begin
              oe_n_nxt = ldi_pkg::SDA_RELEASED;
              state_nxt = ldi_pkg::LDI_WRITE;
            end
          end
        end
        ldi_pkg::LDI_READ:
        begin
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + ldi_pkg::CNT_ONE;
          end
          else if (scl_fall)
          begin
            if (cnt_r == ldi_pkg::BIT_LAST)
            begin
              oe_n_nxt = ldi_pkg::SDA_RELEASED;
              cnt_nxt = ldi_pkg::CNT_ZERO;
              state_nxt = ldi_pkg::LDI_READ_ACK;
            end
            else
            begin
              oe_n_nxt = bit_oe_n(tx_r[7]);
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        ldi_pkg::LDI_READ_ACK:
        begin
          if (scl_rise)
          begin
            acked_nxt = ~sda_s;
          end
          else if (scl_fall)
          begin
            if (acked_r)
            begin
              tx_nxt = {rd_data[6:0], 1'b0};
              oe_n_nxt = bit_oe_n(rd_data[7]);
              rd_taken_nxt = 1'b1;
              state_nxt = ldi_pkg::LDI_READ;
            end
            else
            begin
              oe_n_nxt = ldi_pkg::SDA_RELEASED;
              state_nxt = ldi_pkg::LDI_IGNORE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ldi_pkg::LDI_IDLE;
      cnt_r <= ldi_pkg::CNT_ZERO;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      oe_n_r <= ldi_pkg::SDA_RELEASED;
      acked_r <= 1'b0;
      first_r <= 1'b0;
      wr_data_r <= 8'h00;
      wr_valid_r <= 1'b0;
      wr_first_r <= 1'b0;
      rd_taken_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      oe_n_r <= oe_n_nxt;
      acked_r <= acked_nxt;
      first_r <= first_nxt;
      wr_data_r <= wr_data_nxt;
      wr_valid_r <= wr_valid_nxt;
      wr_first_r <= wr_first_nxt;
      rd_taken_r <= rd_taken_nxt;
      busy_r <= busy_nxt;
    end
  end
  // led output stage; low_power set means frozen outputs
  logic [LEDS-1:0] led_level_r;
  logic [LEDS-1:0] led_level_nxt;
  logic led_od_r;
  logic led_od_nxt;
  always_comb
  begin
    led_level_nxt = led_level_r;
    led_od_nxt = led_od_r;
    if (!low_power)
    begin
      led_level_nxt = led_target;
      led_od_nxt = open_drain_sel;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      led_level_r <= {LEDS{ldi_pkg::LED_LEVEL_RESET}};
      led_od_r <= ldi_pkg::LED_OPEN_DRAIN_RESET;
    end
    else
    begin
      led_level_r <= led_level_nxt;
      led_od_r <= led_od_nxt;
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_r;
  assign wr_data = wr_data_r;
  assign wr_valid = wr_valid_r;
  assign wr_first = wr_first_r;
  assign rd_taken = rd_taken_r;
  assign busy = busy_r;
  assign led_level = led_level_r;
  assign led_open_drain = led_od_r;
endmodule

// ===== verif/ldi_link_properties.sv
`timescale 1ns/1ps
module ldi_link_properties #(
  parameter int unsigned LEDS = ldi_pkg::LED_COUNT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n,
  input wire logic wr_valid,
  input wire logic busy,
  input wire logic low_power,
  input wire logic open_drain_sel,
  input wire logic [LEDS-1:0] led_target,
  input wire logic [LEDS-1:0] led_level,
  input wire logic led_open_drain
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_LED_RESET: assert property ($rose(reset_n) |-> &led_level && !led_open_drain)
    else $error("led reset state");
  AST_LED_FOLLOW: assert property (!low_power |=> led_level == $past(led_target))
    else $error("led not following");
  AST_LED_HOLD: assert property (low_power |=> $stable(led_level) && $stable(led_open_drain))
    else $error("led moved in sleep");
  AST_IDLE_FREE: assert property (!busy |-> sda_oe_n)
    else $error("sda driven while idle");
  AST_SDA_LOW_PHASE: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
    else $error("sda moved with scl high");
  AST_START_BUSY: assert property ($fell(sda_i) && scl_i |-> ##[1:6] busy)
    else $error("start missed");
  AST_STOP_IDLE: assert property ($rose(sda_i) && scl_i |-> ##[1:6] !busy)
    else $error("stop missed");
  AST_WR_ACK: assert property (wr_valid |-> ##[0:2] !sda_oe_n)
    else $error("byte not acked");
  AST_WR_PULSE: assert property (wr_valid |=> !wr_valid)
    else $error("byte pulse long");
  AST_ACK_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("low level cut short");
  cover property (wr_valid);
  cover property ($fell(busy));
  cover property (low_power ##1 !low_power);
endmodule
bind ldi_link ldi_link_properties #(.LEDS(LEDS)) i_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .busy(busy),
  .low_power(low_power), .open_drain_sel(open_drain_sel), .led_target(led_target),
  .led_level(led_level), .led_open_drain(led_open_drain));

// ===== verif/ldi_master.sv
`timescale 1ns/1ps
module ldi_master (
  input wire logic clk_sys,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_m
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data moves mid low phase, clear of the slave turn-round
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_m = b;
    wt(2);
    scl = 1'b1;
    wt(4);
    r = sda_bus;
    scl = 1'b0;
  endtask
  task automatic start();
    wt(2);
    sda_m = 1'b1;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b0;
    wt(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_m = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b1;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(ack_out, ack_in);
  endtask
endmodule

// ===== verif/ldi_link_tb_top.sv
`timescale 1ns/1ps
module ldi_link_tb_top;
  localparam logic [6:0] ADR = ldi_pkg::DEV_ADDR_DEFAULT;
  logic clk_sys, reset_n, low_power, open_drain_sel, sda_oe_n, sda_o, scl, sda_m;
  logic wr_valid, wr_first, rd_taken, busy, od, ak;
  logic [7:0] wr_data, rd_data, rx, d;
  logic [7:0] er[4];
  logic [15:0] led_target, led_level;
  logic [16:0] el;
  logic [16:0] wq[$];
  logic [7:0] rq[$];
  int n_fail, n_compared, n_taken;
  // pull-up on the open-drain line
  wire sda_bus = sda_m & (sda_oe_n | sda_o);
  ldi_link i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wr_data(wr_data), .wr_valid(wr_valid), .wr_first(wr_first), .rd_data(rd_data),
    .rd_taken(rd_taken), .busy(busy), .low_power(low_power), .led_target(led_target),
    .open_drain_sel(open_drain_sel), .led_level(led_level), .led_open_drain(od));
  ldi_master i_mst (.clk_sys(clk_sys), .sda_bus(sda_bus), .scl(scl), .sda_m(sda_m));
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
  always @(negedge clk_sys)
  begin
    if (wr_valid === 1'b1)
      chk({wr_first, 8'h00, wr_data}, wq.size() > 0 ? wq.pop_front() : '1);
    if (rd_taken === 1'b1)
    begin
      n_taken++;
      if (rq.size() > 0)
        rd_data = rq.pop_front();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    low_power = 1'b0;
    open_drain_sel = 1'b0;
    led_target = '1;
    rd_data = 8'h00;
    d = 8'($urandom(32'h30b5));
    repeat (4) @(negedge clk_sys);
    chk({od, led_level}, {1'b0, 16'hffff});
    chk(sda_o, 0);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (int f = 0; f < 2; f++)
    begin
      i_mst.start();
      i_mst.xfer({ADR, 1'b0}, 1'b1, rx, ak);
      chk(ak, 0);
      chk(busy, 1);
      for (int k = 0; k < 3 + f * 2; k++)
      begin
        d = 8'($urandom);
        wq.push_back({k == 0, 8'h00, d});
        i_mst.xfer(d, 1'b1, rx, ak);
        chk(ak, 0);
      end
    end
    i_mst.stop();
    chk(busy, 0);
    chk(17'(wq.size()), 0);
    foreach (er[k])
      er[k] = 8'($urandom);
    rd_data = er[0];
    for (int k = 1; k < 4; k++)
      rq.push_back(er[k]);
    i_mst.start();
    i_mst.xfer({ADR, 1'b1}, 1'b1, rx, ak);
    chk(ak, 0);
    foreach (er[k])
    begin
      i_mst.xfer(8'hff, k == 3, rx, ak);
      chk(rx, er[k]);
    end
    chk(17'(n_taken), 4);
    repeat (12)
    begin
      @(negedge clk_sys);
      chk(sda_oe_n, 1);
    end
    i_mst.stop();
    i_mst.start();
    i_mst.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, rx, ak);
    chk(ak, 1);
    i_mst.xfer(8'h5a, 1'b1, rx, ak);
    chk(ak, 1);
    i_mst.stop();
    el = {1'b0, 16'hffff};
    for (int k = 0; k < 8; k++)
    begin
      low_power = k[0];
      {open_drain_sel, led_target} = 17'($urandom);
      if (!low_power)
        el = {open_drain_sel, led_target};
      repeat (2) @(negedge clk_sys);
      chk({od, led_level}, el);
    end
    end_sim();
  end
endmodule
